// ---- logic/ssi_core.sv ----
// Operation
// R01: transmit MSB first on 0, LSB first on 1
// R02: receive with the same bit order
// R03: mode 00 transmit only, 01 receive only
// R04: transmit buffer write clears empty flag
// R05: active flag set on falling clock edge
// R06: transmit bits change on falling edges
// R07: receive bits sampled on rising edges
// R08: shift flag high falls one to eight
// R09: empty flag at rise, request next fall
// R10: internal clock waits for transmit data
// R11: internal clock starts within one period
// R12: external clock loads on first falling edge
// R13: internal clock halts high until refill
// R14: refill before end sends back to back
// R15: external underrun sets error, request follows
// R16: error holds data out high until abort; code also releases it when a status write of zero clears the error flag
// R17: start cleared finishes byte, then stops
// R18: far side stops start before next byte
// R19: abort stops and clears everything; code keeps bit order, mode and rate
// R20: full byte fills receive buffer, request
// R21: read clears full flag, clock resumes
// R22: external overrun sets error, ignores data
// R23: mode 10 transmits and receives together
// R24: rate code 111 takes external clock
// R25: external clock synchronised, edges detected
//
// The implementer's own choices: the plain strobed port and the register addresses.
module ssi_core (
	input  wire logic                    SYS_CLK,
	input  wire logic                    RST,
	input  wire logic [ssi_pkg::AW-1:0]  ADDR,
	input  wire logic [ssi_pkg::DW-1:0]  WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output logic      [ssi_pkg::DW-1:0]  RDATA,
	output logic                         SERIAL_IRQ,
	input  wire logic                    SERIAL_CLOCK_PIN_I,
	output logic                         SERIAL_CLOCK_PIN_O,
	output logic                         SERIAL_CLOCK_PIN_OE,
	output logic                         SERIAL_DATA_OUT_PIN,
	input  wire logic                    SERIAL_DATA_IN_PIN
);
	logic                   transfer_start_bit_ff;
	logic                   bit_order_select_ff;
	logic [1:0]             transfer_mode_select_ff;
	logic [2:0]             rate_ff;
	logic [ssi_pkg::DW-1:0] tx_buffer_ff;
	logic [ssi_pkg::DW-1:0] rx_buffer_ff;
	logic [ssi_pkg::DW-1:0] tx_shift_ff;
	logic [ssi_pkg::DW-1:0] rx_shift_ff;
	logic                   tx_buffer_empty_flag_ff;
	logic                   rx_buffer_full_flag_ff;
	logic                   tx_underrun_error_flag_ff;
	logic                   rx_overrun_error_flag_ff;
	logic                   transfer_active_flag_ff;
	logic                   shift_active_flag_ff;
	logic                   txf_pend_ff;
	logic                   irq_pend_ff;
	logic                   irq_ff;
	logic [3:0]             fall_cnt_ff;
	logic [3:0]             rise_cnt_ff;
	logic [11:0]            div_ff;
	logic                   sck_int_ff;
	logic                   sck_s1_ff;
	logic                   sck_s2_ff;
	logic                   sck_s3_ff;
	logic                   si_s1_ff;
	logic                   si_s2_ff;
	logic                   so_ff;
	logic [ssi_pkg::DW-1:0] rdata_ff;

	logic                   wr_ctrl;
	logic                   wr_stat;
	logic                   wr_tx;
	logic                   rd_rx;
	logic                   abort;
	logic                   ext_clk;
	logic                   need_tx;
	logic                   need_rx;
	logic                   in_byte;
	logic                   go;
	logic                   gen_run;
	logic                   tick;
	logic                   fall_ev;
	logic                   rise_ev;
	logic                   byte_start;
	logic                   shift_fall;
	logic                   rise_in_byte;
	logic                   byte_end;
	logic                   tx_load;
	logic                   tx_under;
	logic                   rx_done;
	logic [ssi_pkg::DW-1:0] nxt_rx_shift;

	assign wr_ctrl = WR && (ADDR == ssi_pkg::ADDR_CTRL);
	assign wr_stat = WR && (ADDR == ssi_pkg::ADDR_STAT);
	assign wr_tx   = WR && (ADDR == ssi_pkg::ADDR_TXBUF);
	assign rd_rx   = RD && (ADDR == ssi_pkg::ADDR_RXBUF);
	assign abort   = wr_ctrl && WDATA[ssi_pkg::CTRL_ABORT_BIT]; // see R19

	assign ext_clk = (rate_ff == ssi_pkg::RATE_EXT); // see R24
	assign need_tx = (transfer_mode_select_ff == ssi_pkg::MODE_TX) ||
	                 (transfer_mode_select_ff == ssi_pkg::MODE_TRX); // see R03 see R23
	assign need_rx = (transfer_mode_select_ff == ssi_pkg::MODE_RX) ||
	                 (transfer_mode_select_ff == ssi_pkg::MODE_TRX); // see R03 see R23
	assign in_byte = (fall_cnt_ff != 4'h0) || (rise_cnt_ff != 4'h0);

	// internal clock only runs a new byte when data is there and room to receive
	assign go = transfer_start_bit_ff && !tx_underrun_error_flag_ff &&
	            !rx_overrun_error_flag_ff &&
	            (!need_tx || !tx_buffer_empty_flag_ff) &&
	            (!need_rx || !rx_buffer_full_flag_ff); // see R10 see R13 see R21
	assign gen_run = !ext_clk && (in_byte || go); // see R13
	assign tick    = gen_run && (div_ff == ssi_pkg::half_period(rate_ff) - 12'h001);

	// edge events from the internal divider or the synchronised pin
	assign fall_ev = ext_clk ? (sck_s3_ff && !sck_s2_ff) : (tick && sck_int_ff); // see R25
	assign rise_ev = ext_clk ? (!sck_s3_ff && sck_s2_ff) : (tick && !sck_int_ff); // see R25

	assign byte_start   = fall_ev && (fall_cnt_ff == 4'h0) && transfer_start_bit_ff;
	assign shift_fall   = fall_ev && (fall_cnt_ff != 4'h0) && (fall_cnt_ff <= ssi_pkg::LAST_BIT);
	assign rise_in_byte = rise_ev && (fall_cnt_ff != 4'h0);
	assign byte_end     = rise_in_byte && (rise_cnt_ff == ssi_pkg::LAST_BIT);
	assign tx_load      = byte_start && need_tx && !tx_buffer_empty_flag_ff; // see R12 see R14
	assign tx_under     = byte_start && need_tx && tx_buffer_empty_flag_ff; // see R15
	assign rx_done      = byte_end && need_rx && !rx_overrun_error_flag_ff; // see R22

	always_comb begin
		if (bit_order_select_ff) begin
			nxt_rx_shift = {si_s2_ff, rx_shift_ff[ssi_pkg::DW-1:1]}; // see R02
		end else begin
			nxt_rx_shift = {rx_shift_ff[ssi_pkg::DW-2:0], si_s2_ff}; // see R02
		end
	end

	// pin synchronisers
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			sck_s1_ff <= 1'b1;
			sck_s2_ff <= 1'b1;
			sck_s3_ff <= 1'b1;
			si_s1_ff  <= 1'b1;
			si_s2_ff  <= 1'b1;
		end else begin
			sck_s1_ff <= SERIAL_CLOCK_PIN_I; // see R25
			sck_s2_ff <= sck_s1_ff;
			sck_s3_ff <= sck_s2_ff;
			si_s1_ff  <= SERIAL_DATA_IN_PIN;
			si_s2_ff  <= si_s1_ff;
		end
	end

	// control register
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			transfer_start_bit_ff   <= ssi_pkg::CTRL_RESET[ssi_pkg::CTRL_START_BIT];
			bit_order_select_ff     <= ssi_pkg::CTRL_RESET[ssi_pkg::CTRL_DIR_BIT];
			transfer_mode_select_ff <= ssi_pkg::CTRL_RESET[ssi_pkg::CTRL_MODE_LO +: 2];
			rate_ff                 <= ssi_pkg::CTRL_RESET[ssi_pkg::CTRL_RATE_LO +: 3];
		end else if (abort) begin
			transfer_start_bit_ff <= 1'b0; // see R19
		end else if (wr_ctrl) begin
			transfer_start_bit_ff   <= WDATA[ssi_pkg::CTRL_START_BIT];
			bit_order_select_ff     <= WDATA[ssi_pkg::CTRL_DIR_BIT];
			transfer_mode_select_ff <= WDATA[ssi_pkg::CTRL_MODE_LO +: 2];
			rate_ff                 <= WDATA[ssi_pkg::CTRL_RATE_LO +: 3];
		end
	end

	// internal serial clock divider, idles high
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			div_ff     <= 12'h000;
			sck_int_ff <= 1'b1;
		end else if (abort || !gen_run) begin
			div_ff     <= 12'h000;
			sck_int_ff <= 1'b1; // see R13 see R21
		end else if (tick) begin
			div_ff     <= 12'h000;
			sck_int_ff <= !sck_int_ff; // see R11
		end else begin
			div_ff <= div_ff + 12'h001;
		end
	end

	// bit counters
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			fall_cnt_ff <= 4'h0;
			rise_cnt_ff <= 4'h0;
		end else if (abort) begin
			fall_cnt_ff <= 4'h0;
			rise_cnt_ff <= 4'h0;
		end else if (byte_end) begin
			fall_cnt_ff <= 4'h0;
			rise_cnt_ff <= 4'h0;
		end else begin
			if (byte_start) begin
				fall_cnt_ff <= 4'h1;
			end else if (shift_fall) begin
				fall_cnt_ff <= fall_cnt_ff + 4'h1;
			end
			if (rise_in_byte) begin
				rise_cnt_ff <= rise_cnt_ff + 4'h1;
			end
		end
	end

	// transfer and shift activity flags
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			transfer_active_flag_ff <= 1'b0;
			shift_active_flag_ff    <= 1'b0;
		end else if (abort) begin
			transfer_active_flag_ff <= 1'b0;
			shift_active_flag_ff    <= 1'b0;
		end else begin
			if (byte_start) begin
				transfer_active_flag_ff <= 1'b1; // see R05
			end else if (!transfer_start_bit_ff && !in_byte) begin
				transfer_active_flag_ff <= 1'b0; // see R17
			end
			if (byte_start) begin
				shift_active_flag_ff <= 1'b1; // see R08
			end else if (shift_fall && fall_cnt_ff == ssi_pkg::LAST_BIT) begin
				shift_active_flag_ff <= 1'b0; // see R08
			end
		end
	end

	// transmit buffer and empty flag
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			tx_buffer_ff            <= 8'h00;
			tx_buffer_empty_flag_ff <= ssi_pkg::TXF_RESET;
			txf_pend_ff             <= 1'b0;
		end else if (abort) begin
			tx_buffer_ff            <= 8'h00;
			tx_buffer_empty_flag_ff <= ssi_pkg::TXF_RESET; // see R19
			txf_pend_ff             <= 1'b0;
		end else begin
			if (wr_tx && tx_buffer_empty_flag_ff) begin
				tx_buffer_ff <= WDATA;
			end
			if (tx_load) begin
				txf_pend_ff <= 1'b1;
			end else if (rise_ev) begin
				txf_pend_ff <= 1'b0;
			end
			if (txf_pend_ff && rise_ev) begin
				tx_buffer_empty_flag_ff <= 1'b1; // see R09
			end else if (wr_tx) begin
				tx_buffer_empty_flag_ff <= 1'b0; // see R04
			end
		end
	end

	// transmit shifter and data out pin
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			tx_shift_ff <= 8'h00;
			so_ff       <= 1'b1;
		end else if (abort) begin
			tx_shift_ff <= 8'h00;
			so_ff       <= 1'b1;
		end else if (tx_underrun_error_flag_ff || tx_under) begin
			so_ff <= 1'b1; // see R16
		end else if (tx_load) begin
			so_ff <= bit_order_select_ff ? tx_buffer_ff[0] : tx_buffer_ff[7]; // see R01 see R06
			tx_shift_ff <= bit_order_select_ff ? {1'b0, tx_buffer_ff[7:1]}
			                                   : {tx_buffer_ff[6:0], 1'b0}; // see R01
		end else if (shift_fall && need_tx) begin
			so_ff <= bit_order_select_ff ? tx_shift_ff[0] : tx_shift_ff[7]; // see R06
			tx_shift_ff <= bit_order_select_ff ? {1'b0, tx_shift_ff[7:1]}
			                                   : {tx_shift_ff[6:0], 1'b0};
		end else if (!transfer_active_flag_ff || !need_tx) begin
			so_ff <= 1'b1; // see R17
		end
	end

	// receive shifter, buffer and full flag
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rx_shift_ff            <= 8'h00;
			rx_buffer_ff           <= 8'h00;
			rx_buffer_full_flag_ff <= 1'b0;
		end else if (abort) begin
			rx_shift_ff            <= 8'h00;
			rx_buffer_ff           <= 8'h00;
			rx_buffer_full_flag_ff <= 1'b0; // see R19
		end else begin
			if (rise_in_byte && need_rx && !rx_overrun_error_flag_ff) begin
				rx_shift_ff <= nxt_rx_shift; // see R07 see R22
			end
			if (rx_done && !(rx_buffer_full_flag_ff && ext_clk)) begin
				rx_buffer_ff           <= nxt_rx_shift; // see R20
				rx_buffer_full_flag_ff <= 1'b1; // see R20
			end else if (rd_rx) begin
				rx_buffer_full_flag_ff <= 1'b0; // see R21
			end else if (wr_stat && rx_overrun_error_flag_ff &&
			             !WDATA[ssi_pkg::STAT_RX_OVERRUN_ERROR_FLAG_BIT]) begin
				rx_buffer_full_flag_ff <= 1'b0;
			end
		end
	end

	// error flags, cleared by writing zero to them
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			tx_underrun_error_flag_ff <= 1'b0;
			rx_overrun_error_flag_ff  <= 1'b0;
		end else if (abort) begin
			tx_underrun_error_flag_ff <= 1'b0; // see R19
			rx_overrun_error_flag_ff  <= 1'b0;
		end else begin
			if (tx_under && ext_clk) begin
				tx_underrun_error_flag_ff <= 1'b1; // see R15
			end else if (wr_stat && !WDATA[ssi_pkg::STAT_TX_UNDERRUN_ERROR_FLAG_BIT]) begin
				tx_underrun_error_flag_ff <= 1'b0;
			end
			if (rx_done && rx_buffer_full_flag_ff && ext_clk) begin
				rx_overrun_error_flag_ff <= 1'b1; // see R22
			end else if (wr_stat && !WDATA[ssi_pkg::STAT_RX_OVERRUN_ERROR_FLAG_BIT]) begin
				rx_overrun_error_flag_ff <= 1'b0;
			end
		end
	end

	// interrupt request pulse
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			irq_pend_ff <= 1'b0;
			irq_ff      <= 1'b0;
		end else if (abort) begin
			irq_pend_ff <= 1'b0;
			irq_ff      <= 1'b0;
		end else begin
			if ((txf_pend_ff && rise_ev) || (tx_under && ext_clk)) begin
				irq_pend_ff <= 1'b1; // see R09 see R15
			end else if (fall_ev) begin
				irq_pend_ff <= 1'b0;
			end
			irq_ff <= (irq_pend_ff && fall_ev) || rx_done; // see R09 see R20 see R22
		end
	end

	// register read port
	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			rdata_ff <= 8'h00;
		end else if (RD) begin
			unique case (ADDR)
				ssi_pkg::ADDR_CTRL:  rdata_ff <= {transfer_start_bit_ff, 1'b0,
				                                  transfer_mode_select_ff,
				                                  bit_order_select_ff, rate_ff};
				ssi_pkg::ADDR_STAT:  rdata_ff <= {transfer_active_flag_ff, shift_active_flag_ff,
				                                  rx_buffer_full_flag_ff,
				                                  tx_buffer_empty_flag_ff,
				                                  rx_overrun_error_flag_ff,
				                                  tx_underrun_error_flag_ff, 2'b00};
				ssi_pkg::ADDR_RXBUF: rdata_ff <= rx_buffer_ff;
				ssi_pkg::ADDR_TXBUF: rdata_ff <= 8'h00;
			endcase
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	assign RDATA               = rdata_ff;
	assign SERIAL_IRQ          = irq_ff;
	assign SERIAL_CLOCK_PIN_O  = sck_int_ff;
	assign SERIAL_CLOCK_PIN_OE = !ext_clk; // see R24
	assign SERIAL_DATA_OUT_PIN = so_ff;
endmodule : ssi_core

// ---- inc/ssi_pkg.sv ----
package ssi_pkg;
	localparam int DW = 8;
	localparam int AW = 2;

	// register map
	localparam logic [AW-1:0] ADDR_CTRL  = 2'h0;
	localparam logic [AW-1:0] ADDR_STAT  = 2'h1;
	localparam logic [AW-1:0] ADDR_TXBUF = 2'h2;
	localparam logic [AW-1:0] ADDR_RXBUF = 2'h3;

	// serial_control_reg fields
	localparam int CTRL_START_BIT = 7;
	localparam int CTRL_ABORT_BIT = 6;
	localparam int CTRL_MODE_LO   = 4;
	localparam int CTRL_DIR_BIT   = 3;
	localparam int CTRL_RATE_LO   = 0;

	// serial_status_reg fields
	localparam int STAT_ACTIVE_BIT = 7;
	localparam int STAT_SHIFT_BIT  = 6;
	localparam int STAT_RXF_BIT    = 5;
	localparam int STAT_TXF_BIT    = 4;
	localparam int STAT_RX_OVERRUN_ERROR_FLAG_BIT  = 3;
	localparam int STAT_TX_UNDERRUN_ERROR_FLAG_BIT  = 2;

	localparam logic [1:0] MODE_TX  = 2'h0;
	localparam logic [1:0] MODE_RX  = 2'h1;
	localparam logic [1:0] MODE_TRX = 2'h2;

	localparam logic [2:0] RATE_EXT = 3'h7;

	localparam logic [DW-1:0] CTRL_RESET = 8'h00;
	localparam logic          TXF_RESET  = 1'b1;
	localparam logic [3:0]    LAST_BIT   = 4'h7;

	// half period of the internal serial clock, in system clocks
	localparam logic [11:0] HALF_R0 = 12'h800;
	localparam logic [11:0] HALF_R1 = 12'h080;
	localparam logic [11:0] HALF_R2 = 12'h040;
	localparam logic [11:0] HALF_R3 = 12'h020;
	localparam logic [11:0] HALF_R4 = 12'h010;
	localparam logic [11:0] HALF_R5 = 12'h008;
	localparam logic [11:0] HALF_R6 = 12'h004;

	function automatic logic [11:0] half_period(input logic [2:0] rate);
		case (rate)
			3'h0: half_period = HALF_R0;
			3'h1: half_period = HALF_R1;
			3'h2: half_period = HALF_R2;
			3'h3: half_period = HALF_R3;
			3'h4: half_period = HALF_R4;
			3'h5: half_period = HALF_R5;
			default: half_period = HALF_R6;
		endcase
	endfunction : half_period
endpackage : ssi_pkg

// ---- tb/ssi_core_properties.sv ----
module ssi_core_chk (
	input wire logic                   SYS_CLK,
	input wire logic                   RST,
	input wire logic [ssi_pkg::AW-1:0] ADDR,
	input wire logic [ssi_pkg::DW-1:0] WDATA,
	input wire logic                   WR,
	input wire logic                   RD,
	input wire logic [ssi_pkg::DW-1:0] RDATA,
	input wire logic                   SERIAL_IRQ,
	input wire logic                   SERIAL_CLOCK_PIN_O,
	input wire logic                   SERIAL_CLOCK_PIN_OE,
	input wire logic                   SERIAL_DATA_OUT_PIN
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	sequence abort_wr;
		WR && ADDR == ssi_pkg::ADDR_CTRL && WDATA[ssi_pkg::CTRL_ABORT_BIT];
	endsequence
	sequence txbuf_then_stat;
		WR && ADDR == ssi_pkg::ADDR_TXBUF ##2 RD && ADDR == ssi_pkg::ADDR_STAT;
	endsequence
	rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00)
		else $error("read data not zero outside read answer");
	irq_pulse_a: assert property (SERIAL_IRQ |=> !SERIAL_IRQ)
		else $error("interrupt request longer than one cycle");
	txbuf_zero_a: assert property (RD && ADDR == ssi_pkg::ADDR_TXBUF |=> RDATA == 8'h00)
		else $error("tx buffer read not zero");
	txf_clear_a: assert property (txbuf_then_stat |=> !RDATA[ssi_pkg::STAT_TXF_BIT])
		else $error("tx empty flag still set after write");
	abort_status_a: assert property (abort_wr ##2 RD && ADDR == ssi_pkg::ADDR_STAT
		|=> RDATA == 8'h10)
		else $error("status not cleared by abort");
	abort_clk_a: assert property (abort_wr |-> ##[1:3] SERIAL_CLOCK_PIN_O)
		else $error("clock not high after abort");
	oe_rate_a: assert property (WR && ADDR == ssi_pkg::ADDR_CTRL
		&& !WDATA[ssi_pkg::CTRL_ABORT_BIT] |=> SERIAL_CLOCK_PIN_OE ==
		($past(WDATA[2:0]) != ssi_pkg::RATE_EXT))
		else $error("clock enable does not follow rate code");
	data_fall_a: assert property (SERIAL_CLOCK_PIN_OE && $fell(SERIAL_DATA_OUT_PIN)
		|-> !SERIAL_CLOCK_PIN_O)
		else $error("data out changed while clock high");
endmodule : ssi_core_chk

bind ssi_core ssi_core_chk ssi_core_chk_inst (
	.SYS_CLK(SYS_CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
	.RDATA(RDATA), .SERIAL_IRQ(SERIAL_IRQ), .SERIAL_CLOCK_PIN_O(SERIAL_CLOCK_PIN_O),
	.SERIAL_CLOCK_PIN_OE(SERIAL_CLOCK_PIN_OE), .SERIAL_DATA_OUT_PIN(SERIAL_DATA_OUT_PIN));

// ---- tb/ssi_far_end.sv ----
module ssi_far_end (
	input  wire logic sck,
	input  wire logic sdo,
	output logic      sdi,
	output logic      sck_drv
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] got = 16'h0000;
	logic [7:0]  tx_byte = 8'h00;
	logic        lsb = 1'b0;
	int          nbits = 0;
	int          k = 0;
	initial begin
		sdi = 1'b1;
		sck_drv = 1'b1;
	end
	task prep(input logic [7:0] d, input logic l);
		tx_byte = d;
		lsb = l;
		k = 0;
	endtask : prep
	// clock only within frames, high between them
	task frame;
		#1;
		repeat (8) begin
			#16;
			sck_drv = 1'b0;
			#16;
			sck_drv = 1'b1;
		end
		#40;
	endtask : frame
	always @(negedge sck) begin
		sdi = lsb ? tx_byte[k[2:0]] : tx_byte[3'h7 - k[2:0]];
		k = k + 1;
	end
	always @(posedge sck) begin
		#8;
		got = {got[14:0], sdo};
		nbits = nbits + 1;
		#6;
		sdi = ~sdi; // hold time over
	end
endmodule : ssi_far_end

// ---- tb/ssi_core_tb.sv ----
module ssi_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       sys_clk = 1'b0;
	logic       rst = 1'b1;
	logic [1:0] addr = 2'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdata, v;
	logic       irq, sck_o, sck_oe, sdo, sdi, sck_drv, sck_wire;
	int         num_errors = 0;
	int         n_tests = 0;
	int         cycles = 0;
	int         nb = 0;
	int         ni = 0;
	int         n_irq = 0;
	logic [7:0] dat [5] = '{8'ha5, 8'h1e, 8'hc3, 8'h5a, 8'h96};
	assign sck_wire = sck_oe ? sck_o : sck_drv;
	ssi_core ssi_core_inst (.SYS_CLK(sys_clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .SERIAL_IRQ(irq), .SERIAL_CLOCK_PIN_I(sck_wire),
		.SERIAL_CLOCK_PIN_O(sck_o), .SERIAL_CLOCK_PIN_OE(sck_oe),
		.SERIAL_DATA_OUT_PIN(sdo), .SERIAL_DATA_IN_PIN(sdi));
	ssi_far_end ssi_far_end_inst (.sck(sck_wire), .sdo(sdo), .sdi(sdi), .sck_drv(sck_drv));
	initial begin
		forever #2 sys_clk = ~sys_clk;
	end
	task results;
		$display("tests %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : results
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (irq === 1'b1) n_irq <= n_irq + 1;
		if (cycles == 40000) begin
			num_errors++;
			results();
		end
	end
	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("Error %s: expected %h, seen %h", name, exp, got);
			num_errors++;
		end
	endtask : chk
	task wr_reg(input logic [1:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg
	task rd_reg(input logic [1:0] a);
		@(posedge sys_clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask : rd_reg
	task wait_stat(input int b);
		for (int i = 0; i < 600; i++) begin
			rd_reg(ssi_pkg::ADDR_STAT);
			if (v[b] === 1'b1) break;
		end
	endtask : wait_stat
	task wait_bits(input int n, input int lim);
		for (int i = 0; i < lim && ssi_far_end_inst.nbits < n; i++) @(posedge sys_clk);
	endtask : wait_bits
	task abort;
		wr_reg(ssi_pkg::ADDR_CTRL, 8'h40);
		rd_reg(ssi_pkg::ADDR_STAT);
		chk("status after abort", 8'h10, v);
	endtask : abort
	function automatic logic [7:0] rev(input logic [7:0] d);
		for (int i = 0; i < 8; i++) rev[i] = d[7 - i];
	endfunction : rev
	task run_int(input logic [1:0] m, input logic l, input logic [7:0] d);
		int n0;
		int i0;
		n0 = ssi_far_end_inst.nbits;
		i0 = n_irq;
		ssi_far_end_inst.prep(d, l);
		if (m != ssi_pkg::MODE_RX) begin
			wr_reg(ssi_pkg::ADDR_TXBUF, d);
			rd_reg(ssi_pkg::ADDR_STAT);
			chk("tx empty after write", 1'b0, v[ssi_pkg::STAT_TXF_BIT]);
		end
		wr_reg(ssi_pkg::ADDR_CTRL, {2'b10, m, l, 3'h6});
		if (m != ssi_pkg::MODE_RX) begin
			wait_bits(n0 + 8, 200);
			chk("tx byte", l ? rev(d) : d, ssi_far_end_inst.got[7:0]);
		end
		if (m != ssi_pkg::MODE_TX) begin
			wait_stat(ssi_pkg::STAT_RXF_BIT);
			rd_reg(ssi_pkg::ADDR_RXBUF);
			chk("rx byte", d, v);
			rd_reg(ssi_pkg::ADDR_STAT);
			chk("rx full after read", 1'b0, v[ssi_pkg::STAT_RXF_BIT]);
		end
		chk("irq count", (m == ssi_pkg::MODE_TRX) ? 16'h0002 : 16'h0001, 16'(n_irq - i0));
		abort();
	endtask : run_int
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rd_reg(ssi_pkg::ADDR_STAT);
		chk("status reset", 8'h10, v);
		rd_reg(ssi_pkg::ADDR_CTRL);
		chk("ctrl reset", ssi_pkg::CTRL_RESET, v);
		rd_reg(ssi_pkg::ADDR_TXBUF);
		chk("tx buffer read", 8'h00, v);
		for (int i = 0; i < 5; i++)
			run_int(i == 4 ? ssi_pkg::MODE_TRX : (i < 2 ? ssi_pkg::MODE_TX : ssi_pkg::MODE_RX),
				i[0] | (i == 4), dat[i]);
		$display("internal clock modes done");
		wr_reg(ssi_pkg::ADDR_CTRL, 8'h86);
		nb = ssi_far_end_inst.nbits;
		repeat (40) @(posedge sys_clk);
		chk("clock waits for data", 1'b1, sck_o);
		chk("no bits before data", nb[15:0], ssi_far_end_inst.nbits[15:0]);
		wr_reg(ssi_pkg::ADDR_TXBUF, 8'ha5);
		wait_stat(ssi_pkg::STAT_TXF_BIT);
		wr_reg(ssi_pkg::ADDR_TXBUF, 8'h3c);
		wait_bits(nb + 8, 90);
		chk("first byte within bound", 8'ha5, ssi_far_end_inst.got[7:0]);
		wait_bits(nb + 16, 90);
		chk("back to back", 16'ha53c, ssi_far_end_inst.got);
		repeat (60) @(posedge sys_clk);
		chk("clock halted high", 1'b1, sck_o);
		wr_reg(ssi_pkg::ADDR_TXBUF, 8'h81);
		wait_stat(ssi_pkg::STAT_SHIFT_BIT);
		wr_reg(ssi_pkg::ADDR_CTRL, 8'h06);
		wait_bits(nb + 24, 90);
		chk("resumed byte", 8'h81, ssi_far_end_inst.got[7:0]);
		repeat (40) @(posedge sys_clk);
		chk("no byte after stop", nb[15:0] + 16'h0018, ssi_far_end_inst.nbits[15:0]);
		rd_reg(ssi_pkg::ADDR_STAT);
		chk("active after stop", 1'b0, v[ssi_pkg::STAT_ACTIVE_BIT]);
		chk("data out idle", 1'b1, sdo);
		abort();
		$display("continuous transmit done");
		wr_reg(ssi_pkg::ADDR_TXBUF, 8'h69);
		wr_reg(ssi_pkg::ADDR_CTRL, 8'h87);
		ni = n_irq;
		ssi_far_end_inst.frame();
		chk("external tx byte", 8'h69, ssi_far_end_inst.got[7:0]);
		ssi_far_end_inst.frame();
		rd_reg(ssi_pkg::ADDR_STAT);
		chk("tx error", 1'b1, v[ssi_pkg::STAT_TX_UNDERRUN_ERROR_FLAG_BIT]);
		chk("data out held high", 8'hff, ssi_far_end_inst.got[7:0]);
		chk("irq count ext tx", 16'h0002, 16'(n_irq - ni));
		abort();
		wr_reg(ssi_pkg::ADDR_TXBUF, 8'h5a);
		wr_reg(ssi_pkg::ADDR_CTRL, 8'h87);
		ssi_far_end_inst.frame();
		wr_reg(ssi_pkg::ADDR_CTRL, 8'h07);
		ssi_far_end_inst.frame();
		rd_reg(ssi_pkg::ADDR_STAT);
		chk("stopped cleanly", 8'h10, v);
		chk("idle frame data high", 8'hff, ssi_far_end_inst.got[7:0]);
		wr_reg(ssi_pkg::ADDR_CTRL, 8'h97);
		ni = n_irq;
		ssi_far_end_inst.prep(8'h3c, 1'b0);
		ssi_far_end_inst.frame();
		ssi_far_end_inst.prep(8'hc5, 1'b0);
		ssi_far_end_inst.frame();
		rd_reg(ssi_pkg::ADDR_STAT);
		chk("rx error", 1'b1, v[ssi_pkg::STAT_RX_OVERRUN_ERROR_FLAG_BIT]);
		chk("irq count ext rx", 16'h0002, 16'(n_irq - ni));
		rd_reg(ssi_pkg::ADDR_RXBUF);
		chk("rx kept first byte", 8'h3c, v);
		abort();
		$display("external clock done");
		results();
	end
endmodule : ssi_core_tb
